// ==== inc/gamma_dac_pkg.sv ====
package gamma_dac_pkg;

  // ------------------------------------------------------------
  // Channel map and pointer space
  // ------------------------------------------------------------
  localparam int NUM_CHAN = 24;
  localparam logic [5:0] CHAN_FIRST = 6'h00;
  localparam logic [5:0] CHAN_LAST = 6'h17;
  localparam logic [5:0] CHAN_COMMON_A = 6'h12;
  localparam logic [5:0] CHAN_COMMON_B = 6'h13;
  localparam logic [5:0] PTR_REVISION = 6'h3c;
  localparam logic [5:0] PTR_IDENTITY = 6'h3d;
  localparam logic [5:0] PTR_COUNT = 6'h3f;

  // ------------------------------------------------------------
  // Pointer byte and data byte fields
  // ------------------------------------------------------------
  localparam int PTR_CMD_MSB = 7;
  localparam int PTR_CMD_LSB = 6;
  localparam logic [1:0] CMD_REG = 2'h0;
  localparam logic [1:0] CMD_SINGLE = 2'h1;
  localparam logic [1:0] CMD_GENERAL = 2'h2;
  localparam logic [1:0] DEST_NV = 2'h1;
  localparam int LATCH_BIT = 7;
  localparam logic [5:0] DEV_ADDR_HI = 6'h3a;

  // ------------------------------------------------------------
  // Data values and reset values
  // ------------------------------------------------------------
  localparam logic [9:0] CHAN_DEFAULT = 10'h200;
  localparam logic [3:0] COUNT_RESET = 4'h0;
  localparam logic [3:0] COUNT_CODE_MAX = 4'hf;
  localparam int NV_CODE_BITS = 15;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int SINGLE_ACQ_US = 36;
  localparam int GENERAL_ACQ_US = 750;
  localparam int SINGLE_ACQ_CYC = SINGLE_ACQ_US * (CLK_HZ / 1_000_000);
  localparam int GENERAL_ACQ_CYC = GENERAL_ACQ_US * (CLK_HZ / 1_000_000);

  // One stored word as the storage array presents it
  typedef struct packed {
    logic [4:0] prog_count;
    logic [NV_CODE_BITS-1:0] code;
  } nv_word_t;

  typedef logic [NUM_CHAN-1:0][9:0] chan_arr_t;

endpackage : gamma_dac_pkg

// ==== design/nv_word_decode.sv ====
module nv_word_decode (
  input wire gamma_dac_pkg::nv_word_t i_word,
  output logic [9:0] o_data,
  output logic [3:0] o_count_code
);

  // ------------------------------------------------------------
  // Single-error correction, double-error detection
  // ------------------------------------------------------------
  // Hamming positions 1..14, overall parity in bit 0
  logic [3:0] syn;
  logic overall;
  logic [14:0] fixed;

  always_comb begin
    syn = 4'h0;
    for (int i = 1; i < 15; i++) begin
      if (i_word.code[i]) begin
        syn = syn ^ 4'(i);
      end
    end
    overall = ^i_word.code;
    fixed = i_word.code;
    if (overall && syn != 4'hf) begin
      fixed = i_word.code ^ (15'h0001 << syn);
    end
    if ((!overall && syn != 4'h0) || (overall && syn == 4'hf)) begin
      o_data = gamma_dac_pkg::CHAN_DEFAULT;
    end else begin
      o_data = {fixed[14], fixed[13], fixed[12], fixed[11], fixed[10],
                fixed[9], fixed[7], fixed[6], fixed[5], fixed[3]};
    end
  end

  // ------------------------------------------------------------
  // Program count to report code
  // ------------------------------------------------------------
  // Zero and one write share code zero; counts above sixteen saturate
  always_comb begin
    if (i_word.prog_count <= 5'h01) begin
      o_count_code = gamma_dac_pkg::COUNT_RESET;
    end else if (i_word.prog_count > 5'h10) begin
      o_count_code = gamma_dac_pkg::COUNT_CODE_MAX;
    end else begin
      o_count_code = 4'(i_word.prog_count - 5'h01);
    end
  end

endmodule : nv_word_decode

// ==== design/gamma_dac_cmd_regs.sv ====
// Behaviour
// - General acquire loads all channels after 750us
// - Single acquire pointer 01, channels 0..23 acked
// - Single acquire loads one channel after 36us
// - Count report at 3f, read-only, acquire-updated
// - Single acquire reports that channel's count
// - General acquire reports highest channel count
// - Count code: 0,1 give 0, 2..16 give count-1, above 16 give f
// - Single failed stored bit gets corrected
// - Multiple failed bits load default 1000000000; here only two are caught, three can be miscorrected
// - Pointer 3d reads fixed identity code
// - Pointer 3c reads die revision code
// - Top data bits 01 mean nonvolatile destination
// - Direction bit low writes, high reads
// - Register write pointer 00, channels 0..23 acked
// - Two bytes, MSB first, commit after second
// - Pointer advances after each complete pair; held at non-channel pointers such as 3c, 3d, 3f
// - Partial pair at stop/restart is discarded
// - Read: pointer write, restart, read address
// - Read returns two bytes, MSB first
// - Multi-read walks channels upward from pointer
// - Data bit 15 moves values to outputs
// - General acquire pointer 10 with valid channel
// - Channel map: 18 gamma, 2 common, 4 gamma
module gamma_dac_cmd_regs #(
  parameter int GENERAL_ACQ_CYC = gamma_dac_pkg::GENERAL_ACQ_CYC,
  parameter logic [15:0] DIE_IDENTITY_CODE = 16'h6a3c, // Arbitrary value
  parameter logic [15:0] DIE_REV = 16'h0003 // Arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  input wire logic i_address_strap_pin,
  input wire logic i_bank_select_pin,
  output logic [5:0] o_nv_chan,
  output logic o_nv_bank,
  input wire gamma_dac_pkg::nv_word_t i_nv,
  output gamma_dac_pkg::chan_arr_t o_chan_out
);

  // ------------------------------------------------------------
  // Types and helpers
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    BUS_IDLE = 6'b000001,
    BUS_ADDR = 6'b000010,
    BUS_PTR = 6'b000100,
    BUS_WDATA = 6'b001000,
    BUS_RDATA = 6'b010000,
    BUS_IGNORE = 6'b100000
  } bus_state_t;

  typedef enum logic [2:0] {
    ACQ_IDLE = 3'b001,
    ACQ_WAIT = 3'b010,
    ACQ_LOAD = 3'b100
  } acq_state_t;

  // Wait counter must hold the longer of the two waits, whatever the override
  localparam int CNT_MAX = (GENERAL_ACQ_CYC > gamma_dac_pkg::SINGLE_ACQ_CYC) ?
                           GENERAL_ACQ_CYC : gamma_dac_pkg::SINGLE_ACQ_CYC;
  localparam int CNT_W = $clog2(CNT_MAX + 1);

  function automatic logic is_chan(input logic [5:0] p);
    return p <= gamma_dac_pkg::CHAN_LAST;
  endfunction : is_chan

  function automatic logic [15:0] rd_word(input logic [5:0] p,
                                          input gamma_dac_pkg::chan_arr_t regs,
                                          input logic [3:0] cnt);
    if (is_chan(p)) begin
      return {6'h00, regs[p[4:0]]};
    end else if (p == gamma_dac_pkg::PTR_IDENTITY) begin
      return DIE_IDENTITY_CODE;
    end else if (p == gamma_dac_pkg::PTR_REVISION) begin
      return DIE_REV;
    end else if (p == gamma_dac_pkg::PTR_COUNT) begin
      return {12'h000, cnt};
    end
    return 16'h0000;
  endfunction : rd_word

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic strap_m, strap_s, bank_m, bank_s;

  // Two flops before use; third stage only for edge detection
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      {strap_m, strap_s, bank_m, bank_s} <= 4'h0;
    end else begin
      {scl_m, scl_s, scl_d} <= {i_scl, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {i_sda, sda_m, sda_s};
      {strap_m, strap_s} <= {i_address_strap_pin, strap_m};
      {bank_m, bank_s} <= {i_bank_select_pin, bank_m};
    end
  end

  // ------------------------------------------------------------
  // Bus events and decisions
  // ------------------------------------------------------------
  bus_state_t state_reg;
  logic [7:0] rx_sh, tx_sh, wr_hi;
  logic [3:0] bit_cnt;
  logic in_ack, rw, byte_sel, mnack;
  logic [5:0] ptr;
  logic [1:0] cmd;
  logic pend_single, pend_general;
  gamma_dac_pkg::chan_arr_t chan_reg, out_reg;
  logic [3:0] count_reg;

  logic rise, fall, start_c, stop_c, byte_done, ack_end;
  logic addr_hit, ptr_ok, ack_now, commit;
  logic [5:0] ptr_inc;
  logic [15:0] nxt_word;
  logic [7:0] next_tx;

  assign rise = scl_s & ~scl_d;
  assign fall = ~scl_s & scl_d;
  assign start_c = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
  assign byte_done = fall & ~in_ack & (bit_cnt == 4'h8);
  assign ack_end = fall & in_ack;
  assign addr_hit = rx_sh[7:1] == {gamma_dac_pkg::DEV_ADDR_HI, strap_s};
  assign ptr_inc = is_chan(ptr) ? ptr + 6'h01 : ptr;

  // Pointer byte acceptance per command kind
  always_comb begin
    unique case (rx_sh[gamma_dac_pkg::PTR_CMD_MSB:gamma_dac_pkg::PTR_CMD_LSB])
      gamma_dac_pkg::CMD_REG: begin
        ptr_ok = is_chan(rx_sh[5:0])
                 || rx_sh[5:0] == gamma_dac_pkg::PTR_REVISION
                 || rx_sh[5:0] == gamma_dac_pkg::PTR_IDENTITY
                 || rx_sh[5:0] == gamma_dac_pkg::PTR_COUNT;
      end
      gamma_dac_pkg::CMD_SINGLE: ptr_ok = is_chan(rx_sh[5:0]);
      gamma_dac_pkg::CMD_GENERAL: ptr_ok = is_chan(rx_sh[5:0]);
      default: ptr_ok = 1'b0;
    endcase
  end

  // Which received bytes get an acknowledge
  always_comb begin
    unique case (state_reg)
      BUS_ADDR: ack_now = addr_hit;
      BUS_PTR: ack_now = ptr_ok;
      BUS_WDATA: ack_now = 1'b1;
      default: ack_now = 1'b0;
    endcase
  end

  // Second byte of a register write; NV destination is not committed here
  assign commit = byte_done && state_reg == BUS_WDATA && byte_sel
                  && cmd == gamma_dac_pkg::CMD_REG && is_chan(ptr)
                  && wr_hi[7:6] != gamma_dac_pkg::DEST_NV;

  // Next byte to shift out: high byte first, then low
  assign nxt_word = (state_reg == BUS_RDATA && byte_sel) ?
                    rd_word(ptr_inc, chan_reg, count_reg) :
                    rd_word(ptr, chan_reg, count_reg);
  assign next_tx = (state_reg == BUS_RDATA && !byte_sel) ?
                   nxt_word[7:0] : nxt_word[15:8];

  // ------------------------------------------------------------
  // Serial protocol engine
  // ------------------------------------------------------------
  // Start and stop abort any byte; a partial pair simply never commits
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_reg <= BUS_IDLE;
      bit_cnt <= 4'h0;
      in_ack <= 1'b0;
      rx_sh <= 8'h00;
      rw <= 1'b0;
      byte_sel <= 1'b0;
      mnack <= 1'b0;
      wr_hi <= 8'h00;
      ptr <= 6'h00;
      cmd <= gamma_dac_pkg::CMD_REG;
    end else if (start_c || stop_c) begin
      state_reg <= start_c ? BUS_ADDR : BUS_IDLE;
      bit_cnt <= 4'h0;
      in_ack <= 1'b0;
      byte_sel <= 1'b0;
    end else begin
      if (rise && !in_ack && bit_cnt < 4'h8) begin
        rx_sh <= {rx_sh[6:0], sda_s};
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (rise && in_ack) begin
        mnack <= sda_s;
      end
      if (byte_done) begin
        in_ack <= ack_now | (state_reg == BUS_RDATA);
        unique case (state_reg)
          BUS_ADDR: begin
            rw <= rx_sh[0];
            if (!addr_hit) state_reg <= BUS_IGNORE;
          end
          BUS_PTR: begin
            ptr <= rx_sh[5:0];
            cmd <= rx_sh[7:6];
            if (!ptr_ok) state_reg <= BUS_IGNORE;
          end
          BUS_WDATA: begin
            byte_sel <= ~byte_sel;
            if (!byte_sel) wr_hi <= rx_sh;
            else if (cmd == gamma_dac_pkg::CMD_REG) ptr <= ptr_inc;
          end
          default: ;
        endcase
      end
      if (ack_end) begin
        in_ack <= 1'b0;
        bit_cnt <= 4'h0;
        unique case (state_reg)
          BUS_ADDR: state_reg <= rw ? BUS_RDATA : BUS_PTR;
          BUS_PTR: state_reg <= BUS_WDATA;
          BUS_RDATA: begin
            if (mnack) state_reg <= BUS_IGNORE;
            byte_sel <= ~byte_sel;
            if (byte_sel) ptr <= ptr_inc;
          end
          default: ;
        endcase
      end
    end
  end

  // Open-drain data line: acknowledge slots and read bits
  // Enable kept in its own flop so the pin sees no logic after it
  logic sda_oe_n_reg;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sda_oe_n_reg <= 1'b1;
      tx_sh <= 8'h00;
    end else if (start_c || stop_c) begin
      sda_oe_n_reg <= 1'b1;
    end else if (byte_done) begin
      sda_oe_n_reg <= ~ack_now;
    end else if (ack_end) begin
      if ((state_reg == BUS_ADDR && rw) || (state_reg == BUS_RDATA && !mnack)) begin
        tx_sh <= next_tx;
        sda_oe_n_reg <= next_tx[7];
      end else begin
        sda_oe_n_reg <= 1'b1;
      end
    end else if (fall && state_reg == BUS_RDATA && bit_cnt != 4'h0 && bit_cnt < 4'h8) begin
      sda_oe_n_reg <= tx_sh[3'(4'h7 - bit_cnt)];
    end
  end

  assign o_sda_oe_n = sda_oe_n_reg;
  assign o_sda_out = 1'b0;

  // Acquire commands wait for the closing stop or repeated start
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pend_single <= 1'b0;
      pend_general <= 1'b0;
    end else if (start_c || stop_c) begin
      pend_single <= 1'b0;
      pend_general <= 1'b0;
    end else if (byte_done && state_reg == BUS_PTR && ptr_ok) begin
      pend_single <= rx_sh[7:6] == gamma_dac_pkg::CMD_SINGLE;
      pend_general <= rx_sh[7:6] == gamma_dac_pkg::CMD_GENERAL;
    end
  end

  // ------------------------------------------------------------
  // Acquire sequencer
  // ------------------------------------------------------------
  acq_state_t acq_state;
  logic [CNT_W-1:0] acq_cnt;
  logic acq_all;
  logic [3:0] max_code;
  logic [9:0] dec_data;
  logic [3:0] dec_code;
  logic go_single, go_general;

  assign go_single = pend_single & (start_c | stop_c);
  assign go_general = (pend_general & (start_c | stop_c)) | (bank_s != o_nv_bank);

  nv_word_decode u_decode (
    .i_word(i_nv),
    .o_data(dec_data),
    .o_count_code(dec_code)
  );

  // Reset starts a full load, as at power-up; a new request restarts
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      acq_state <= ACQ_WAIT;
      acq_cnt <= CNT_W'(GENERAL_ACQ_CYC - 1);
      acq_all <= 1'b1;
      max_code <= gamma_dac_pkg::COUNT_RESET;
      count_reg <= gamma_dac_pkg::COUNT_RESET;
      o_nv_chan <= gamma_dac_pkg::CHAN_FIRST;
      o_nv_bank <= 1'b0;
    end else if (go_general) begin
      o_nv_bank <= bank_s;
      acq_state <= ACQ_WAIT;
      acq_cnt <= CNT_W'(GENERAL_ACQ_CYC - 1);
      acq_all <= 1'b1;
      o_nv_chan <= gamma_dac_pkg::CHAN_FIRST;
    end else if (go_single) begin
      acq_state <= ACQ_WAIT;
      acq_cnt <= CNT_W'(gamma_dac_pkg::SINGLE_ACQ_CYC - 1);
      acq_all <= 1'b0;
      o_nv_chan <= ptr;
    end else begin
      unique case (acq_state)
        ACQ_IDLE: ;
        ACQ_WAIT: begin
          max_code <= gamma_dac_pkg::COUNT_RESET;
          if (acq_cnt == '0) acq_state <= ACQ_LOAD;
          else acq_cnt <= acq_cnt - CNT_W'(1);
        end
        ACQ_LOAD: begin
          if (!acq_all) begin
            count_reg <= dec_code;
            acq_state <= ACQ_IDLE;
          end else if (o_nv_chan == gamma_dac_pkg::CHAN_LAST) begin
            count_reg <= (dec_code > max_code) ? dec_code : max_code;
            acq_state <= ACQ_IDLE;
          end else begin
            if (dec_code > max_code) max_code <= dec_code;
            o_nv_chan <= o_nv_chan + 6'h01;
          end
        end
        default: acq_state <= ACQ_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Channel registers and output latches
  // ------------------------------------------------------------
  // Acquire load wins over a bus write landing in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      for (int i = 0; i < gamma_dac_pkg::NUM_CHAN; i++) begin
        chan_reg[i] <= gamma_dac_pkg::CHAN_DEFAULT;
        out_reg[i] <= gamma_dac_pkg::CHAN_DEFAULT;
      end
    end else if (acq_state == ACQ_LOAD) begin
      chan_reg[o_nv_chan[4:0]] <= dec_data;
      out_reg[o_nv_chan[4:0]] <= dec_data;
    end else if (commit) begin
      chan_reg[ptr[4:0]] <= {wr_hi[1:0], rx_sh};
      if (wr_hi[gamma_dac_pkg::LATCH_BIT]) begin
        for (int i = 0; i < gamma_dac_pkg::NUM_CHAN; i++) begin
          out_reg[i] <= (5'(i) == ptr[4:0]) ? {wr_hi[1:0], rx_sh} : chan_reg[i];
        end
      end
    end
  end

  assign o_chan_out = out_reg;

endmodule : gamma_dac_cmd_regs

// ==== verification/gamma_dac_checker.sv ====
module gamma_dac_checker #(
  parameter int GENERAL_ACQ_CYC = 50
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_bank_select_pin,
  input wire logic o_sda_out,
  input wire logic o_sda_oe_n,
  input wire logic [5:0] o_nv_chan,
  input wire logic o_nv_bank,
  input wire gamma_dac_pkg::chan_arr_t o_chan_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  // Cycles since release; saturates so it never wraps
  int up_cnt;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      up_cnt <= 0;
    end else if (up_cnt < 1000000) begin
      up_cnt <= up_cnt + 1;
    end
  end

  // Pin and storage handshake outputs right after reset
  property p_reset_vals;
    $rose(i_resetn) |-> o_sda_oe_n && o_nv_chan == 6'h00 && !o_nv_bank;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("outputs not at reset values");

  // Slack of two cycles covers the reset-edge count
  property p_powerup_wait;
    up_cnt < GENERAL_ACQ_CYC - 2 |->
      o_chan_out == {gamma_dac_pkg::NUM_CHAN{gamma_dac_pkg::CHAN_DEFAULT}};
  endproperty
  a_powerup_wait: assert property (p_powerup_wait)
    else $error("outputs left default before the acquire wait ended");

  property p_sda_out_low;
    o_sda_out == 1'b0;
  endproperty
  a_sda_out_low: assert property (p_sda_out_low)
    else $error("data pin driven high");

  // A change while the clock is high would look like start or stop
  property p_ack_setup;
    $fell(o_sda_oe_n) |-> !i_scl;
  endproperty
  a_ack_setup: assert property (p_ack_setup)
    else $error("data pulled low while clock high");

  property p_bit_hold;
    $fell(o_sda_oe_n) |=> !o_sda_oe_n [*7];
  endproperty
  a_bit_hold: assert property (p_bit_hold)
    else $error("low bit released too early");

  property p_nv_range;
    o_nv_chan <= gamma_dac_pkg::CHAN_LAST;
  endproperty
  a_nv_range: assert property (p_nv_range)
    else $error("storage channel index out of map");

  property p_bank_follow;
    (i_resetn && $stable(i_bank_select_pin)) [*8] |-> o_nv_bank == i_bank_select_pin;
  endproperty
  a_bank_follow: assert property (p_bank_follow)
    else $error("storage bank does not follow pin");

  // Full load walks channels 0 to 3 on consecutive cycles
  property p_sweep;
    $past(o_nv_chan) == 6'h00 && o_nv_chan == 6'h01 |=>
      o_nv_chan == 6'h02 ##1 o_nv_chan == 6'h03;
  endproperty
  a_sweep: assert property (p_sweep)
    else $error("general load skipped a channel");
endmodule : gamma_dac_checker

bind gamma_dac_cmd_regs gamma_dac_checker #(.GENERAL_ACQ_CYC(GENERAL_ACQ_CYC)) gamma_dac_checker_i (
  .i_clk(i_clk),
  .i_resetn(i_resetn),
  .i_scl(i_scl),
  .i_bank_select_pin(i_bank_select_pin),
  .o_sda_out(o_sda_out),
  .o_sda_oe_n(o_sda_oe_n),
  .o_nv_chan(o_nv_chan),
  .o_nv_bank(o_nv_bank),
  .o_chan_out(o_chan_out)
);

// ==== verification/gamma_bus_master.sv ====
module gamma_bus_master (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DEV = {gamma_dac_pkg::DEV_ADDR_HI, 1'b0};
  // One bus phase in system cycles, a third of a bit; raise it for a slow master
  int half_cyc = 10;

  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic tick();
    repeat (half_cyc) @(negedge i_clk);
  endtask : tick

  // Sda only moves while scl is low, except in start and stop
  task automatic start_cond();
    o_sda_low = 1'b0;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda_low = 1'b1;
    tick();
    o_scl = 1'b0;
    tick();
  endtask : start_cond

  task automatic stop_cond();
    o_sda_low = 1'b1;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda_low = 1'b0;
    tick();
  endtask : stop_cond

  task automatic bit_io(input logic b, output logic r);
    o_sda_low = !b;
    tick();
    o_scl = 1'b1;
    tick();
    r = i_sda;
    o_scl = 1'b0;
    tick();
  endtask : bit_io

  task automatic byte_io(input logic [7:0] tx, input logic give_ack, output logic [7:0] rx,
                         output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(!give_ack, r);
    ack = !r;
  endtask : byte_io

  task automatic wr(input logic [7:0] b[$], output int n_ack);
    logic [7:0] rx;
    logic ack;
    n_ack = 0;
    b.push_front({DEV, 1'b0}); // Direction low for a write
    start_cond();
    foreach (b[i]) begin
      byte_io(b[i], 1'b0, rx, ack);
      n_ack += (ack === 1'b1) ? 1 : 0;
    end
    stop_cond();
  endtask : wr

  task automatic rd(input logic [7:0] ptr, input int n, output logic [15:0] w[$]);
    logic [7:0] rx;
    logic [7:0] hi;
    logic ack;
    w = {};
    start_cond();
    byte_io({DEV, 1'b0}, 1'b0, rx, ack);
    byte_io(ptr, 1'b0, rx, ack);
    start_cond(); // Repeated start turns the bus round
    byte_io({DEV, 1'b1}, 1'b0, rx, ack); // Direction high for a read
    for (int i = 0; i < n; i++) begin
      byte_io(8'hff, 1'b1, hi, ack); // High byte always acked
      byte_io(8'hff, i < n - 1, rx, ack); // Last byte left unacked
      w.push_back({hi, rx});
    end
    stop_cond();
  endtask : rd
endmodule : gamma_bus_master

// ==== verification/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GEN_CYC = 50;
  localparam logic [15:0] ID_VAL = 16'h5a17; // Arbitrary value
  localparam logic [15:0] REV_VAL = 16'h0002; // Arbitrary value
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic bank = 1'b0;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe_n;
  logic sda_line;
  logic [5:0] nv_chan;
  logic nv_bank;
  gamma_dac_pkg::nv_word_t nv;
  gamma_dac_pkg::chan_arr_t chan_out;
  int n_fail = 0;
  int check_count = 0;

  always #12.5 clk = ~clk;
  // Open-drain line with pull-up
  assign sda_line = (sda_oe_n ? 1'b1 : sda_out) & !sda_low;

  function automatic logic [9:0] dat(input int c);
    return 10'(c * 37 + 5);
  endfunction : dat
  function automatic logic [9:0] exp_ch(input int c);
    return (c == 10) ? gamma_dac_pkg::CHAN_DEFAULT : dat(c);
  endfunction : exp_ch
  function automatic logic [3:0] code_of(input int n);
    return (n <= 1) ? 4'h0 : ((n > 16) ? 4'hf : 4'(n - 1));
  endfunction : code_of
  function automatic logic [14:0] enc(input logic [9:0] d);
    int pos[10] = '{3, 5, 6, 7, 9, 10, 11, 12, 13, 14};
    logic [14:0] w;
    w = '0;
    for (int i = 0; i < 10; i++) w[pos[i]] = d[i];
    for (int p = 1; p < 16; p = p * 2) begin
      for (int i = 3; i < 15; i++) begin
        if ((i & p) != 0 && i != p) w[p] = w[p] ^ w[i];
      end
    end
    w[0] = ^w[14:1];
    return w;
  endfunction : enc

  // Storage array: channel 9 has one failed bit, channel 10 two
  always_comb begin
    nv.prog_count = (nv_chan < 6'h11) ? 5'(nv_chan) : 5'h01;
    nv.code = enc(dat(int'(nv_chan)));
    if (nv_chan == 6'h09) nv.code = nv.code ^ 15'h0020;
    if (nv_chan == 6'h0a) nv.code = nv.code ^ 15'h0048;
  end

  // Bank pin steady until after the last acquire command
  gamma_dac_cmd_regs #(.GENERAL_ACQ_CYC(GEN_CYC), .DIE_IDENTITY_CODE(ID_VAL), .DIE_REV(REV_VAL))
      gamma_dac_cmd_regs_i (
    .i_clk(clk),
    .i_resetn(resetn),
    .i_scl(scl),
    .i_sda(sda_line),
    .o_sda_out(sda_out),
    .o_sda_oe_n(sda_oe_n),
    .i_address_strap_pin(1'b0),
    .i_bank_select_pin(bank),
    .o_nv_chan(nv_chan),
    .o_nv_bank(nv_bank),
    .i_nv(nv),
    .o_chan_out(chan_out)
  );
  gamma_bus_master gamma_bus_master_i (
    .i_clk(clk),
    .i_sda(sda_line),
    .o_scl(scl),
    .o_sda_low(sda_low)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr_chk(input logic [7:0] b[$], input int exp_acks);
    int n;
    gamma_bus_master_i.wr(b, n);
    check(16'(n), 16'(exp_acks));
  endtask : wr_chk
  task automatic rd_chk(input logic [7:0] ptr, input logic [15:0] e[$]);
    logic [15:0] w[$];
    gamma_bus_master_i.rd(ptr, e.size(), w);
    foreach (e[i]) check(w[i], e[i]);
  endtask : rd_chk
  task automatic chk_all();
    for (int c = 0; c < gamma_dac_pkg::NUM_CHAN; c++) check({6'h0, chan_out[c]}, {6'h0, exp_ch(c)});
  endtask : chk_all
  task automatic summarize();
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // Hang guard
  initial begin
    repeat (99000) @(posedge clk);
    n_fail++;
    summarize();
  end

  initial begin
    logic [7:0] cs[4];
    logic [7:0] bad[4];
    logic [9:0] e;
    cs = '{8'h10, 8'h01, 8'h00, 8'h02};
    bad = '{8'h18, 8'h58, 8'hc0, 8'h98};
    e = exp_ch(6);
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    repeat (GEN_CYC + 150) @(negedge clk);
    chk_all();
    rd_chk(8'h3f, '{16'h000f});
    gamma_bus_master_i.half_cyc = 20;
    rd_chk(8'h3d, '{ID_VAL});
    gamma_bus_master_i.half_cyc = 10;
    rd_chk(8'h3c, '{REV_VAL});
    foreach (bad[i]) wr_chk('{bad[i]}, 1);
    // Two pairs then a lone high byte, none latched
    wr_chk('{8'h04, 8'h01, 8'h23, 8'h02, 8'h34, 8'h03}, 7);
    check({6'h0, chan_out[4]}, {6'h0, exp_ch(4)});
    rd_chk(8'h04, '{16'h0123, 16'h0234, {6'h0, e}});
    wr_chk('{8'h06, {6'h20, e[9:8]}, e[7:0]}, 4);
    check({6'h0, chan_out[5]}, 16'h0234);
    wr_chk('{8'h07, 8'h41, 8'h11}, 4);
    // Storage destination: stay off the bus while it would be programming
    repeat (10000) @(negedge clk);
    rd_chk(8'h07, '{{6'h0, exp_ch(7)}});
    foreach (cs[i]) begin
      wr_chk('{cs[i], 8'h83, 8'hff}, 4);
      wr_chk('{8'h40 | cs[i]}, 2);
      repeat (1280) @(negedge clk);
      check({6'h0, chan_out[cs[i]]}, 16'h03ff);
      repeat (320) @(negedge clk);
      check({6'h0, chan_out[cs[i]]}, {6'h0, exp_ch(cs[i])});
      rd_chk(8'h3f, '{{12'h0, code_of(cs[i])}});
    end
    wr_chk('{8'h3f, 8'h00, 8'h05}, 4);
    rd_chk(8'h3f, '{16'h0001});
    wr_chk('{8'h85}, 2);
    repeat (GEN_CYC + 150) @(negedge clk);
    chk_all();
    rd_chk(8'h3f, '{16'h000f});
    // Spoil one output, then a bank flip must reload every channel
    wr_chk('{8'h04, 8'h81, 8'h55}, 4);
    bank = 1'b1;
    repeat (GEN_CYC + 150) @(negedge clk);
    check(16'(nv_bank), 16'h0001);
    chk_all();
    summarize();
  end
endmodule : tb_top
